// File: csl_top.sv
// controller operating state tracker and indicator driver
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module csl_top #(
   parameter int unsigned TICK_CYCLES = csl_pkg::TICK_CYCLES,
   parameter int unsigned HOLDUP_CYCLES = csl_pkg::HOLDUP_CYCLES
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // boot checks
   input wire logic selftest_done_i,
   input wire logic fw_valid_i,
   input wire logic app_valid_i,
   // system events
   input wire logic sys_error_i,
   input wire logic app_error_i,
   input wire logic fatal_error_i,
   input wire logic power_fail_i,
   // fault sources
   input wire logic [31:0] fault_first_i,
   input wire logic [31:0] fault_second_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // indicators and status
   output logic run_led_o,
   output logic err_led_o,
   output logic io_led_o,
   output logic task_enable_o,
   output logic shutdown_o,
   output logic irq_o
);

   //==========================================================================
   // declarations
   csl_pkg::csl_state_e state_q, state_d;
   logic [csl_pkg::TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   logic [2:0] pattern;
   logic [1:0] boot_phase_q;
   logic [10:0] boot_ms_q;
   logic boot_done;
   logic [csl_pkg::HOLD_W-1:0] hold_cnt_q;
   logic hold_done_q;
   logic locked_q;
   logic unsaved_q;
   logic [31:0] fault1_q, fault2_q;
   logic ext_err;
   logic ext_err_prev_q;
   logic pwr_prev_q;
   logic [csl_pkg::CMD_W-1:0] cmd;
   logic any_reset;
   logic [4:0] irq_stat_q, irq_en_q, irq_clr, events;
   logic [3:0] code;

   //==========================================================================
   // command decode, one-cycle pulses
   assign cmd = (wr_i && addr_i == csl_pkg::ADDR_CMD) ?
      wdata_i[csl_pkg::CMD_W-1:0] : {csl_pkg::CMD_W{1'b0}};
   assign any_reset = cmd[csl_pkg::CMD_RST_WARM] |
      cmd[csl_pkg::CMD_RST_COLD] | cmd[csl_pkg::CMD_RST_ORIG];
   assign irq_clr = (wr_i && addr_i == csl_pkg::ADDR_IRQ_CLR) ?
      wdata_i[4:0] : 5'h00;

   //==========================================================================
   // 1 ms tick
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == csl_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   csl_flash u_flash (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .tick_i(tick_q),
      .pattern_o(pattern)
   );

   //==========================================================================
   // boot indicator phases
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         boot_phase_q <= 2'h0;
         boot_ms_q <= 11'h000;
      end else if (state_q == csl_pkg::CSL_BOOT && tick_q &&
                   !(boot_phase_q == 2'h2 &&
                     boot_ms_q == csl_pkg::BOOT_PHASE_MS)) begin
         if (boot_ms_q == csl_pkg::BOOT_PHASE_MS &&
             boot_phase_q != 2'h2) begin
            boot_ms_q <= 11'h000;
            boot_phase_q <= boot_phase_q + 2'h1;
         end else begin
            boot_ms_q <= boot_ms_q + 11'h001;
         end
      end
   end
   // checks may finish early; the last phase is still shown in full
   assign boot_done = selftest_done_i && boot_phase_q == 2'h2 &&
      boot_ms_q == csl_pkg::BOOT_PHASE_MS;

   //==========================================================================
   // supply hold-up
   always_ff @(posedge mclk_i) begin
      if (reset_i || !power_fail_i) begin
         hold_cnt_q <= '0;
         hold_done_q <= 1'b0;
      end else if (hold_cnt_q == csl_pkg::HOLD_W'(HOLDUP_CYCLES - 1)) begin
         hold_done_q <= 1'b1;
      end else begin
         hold_cnt_q <= hold_cnt_q + 1'b1;
      end
   end

   //==========================================================================
   // fault words, lock and unsaved flag
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         fault1_q <= 32'h0000_0000;
         fault2_q <= 32'h0000_0000;
      end else begin
         fault1_q <= fault_first_i;
         fault2_q <= fault_second_i;
      end
   end
   assign ext_err = (fault1_q != 32'h0000_0000) ||
      (fault2_q != 32'h0000_0000);

   // only a power cycle clears the lock
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         locked_q <= 1'b0;
      end else if (fatal_error_i && state_q != csl_pkg::CSL_BOOT &&
                   state_q != csl_pkg::CSL_FW_MISSING) begin
         locked_q <= 1'b1;
      end
   end

   // stored application replaces working copy at power cycle
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         unsaved_q <= 1'b0;
      end else if (cmd[csl_pkg::CMD_SAVE_BOOT] ||
                   cmd[csl_pkg::CMD_DOWNLOAD]) begin
         unsaved_q <= 1'b0;
      end else if (cmd[csl_pkg::CMD_ONLINE] &&
                   (state_q == csl_pkg::CSL_RUN ||
                    state_q == csl_pkg::CSL_STOPPED)) begin
         unsaved_q <= 1'b1;
      end
   end

   //==========================================================================
   // state transitions by fixed priority
   always_comb begin
      state_d = state_q;
      case (state_q)
         csl_pkg::CSL_BOOT: begin
            if (boot_done) begin
               if (!fw_valid_i) begin
                  state_d = csl_pkg::CSL_FW_MISSING;
               end else if (!app_valid_i) begin
                  state_d = csl_pkg::CSL_EMPTY;
               end else begin
                  state_d = csl_pkg::CSL_STOPPED;
               end
            end
         end
         // nothing executes until new firmware and a power cycle
         csl_pkg::CSL_FW_MISSING: state_d = csl_pkg::CSL_FW_MISSING;
         csl_pkg::CSL_OFF: state_d = csl_pkg::CSL_OFF;
         default: begin
            if (power_fail_i &&
                (hold_done_q || (state_q != csl_pkg::CSL_RUN &&
                                 state_q != csl_pkg::CSL_RUN_BP))) begin
               state_d = csl_pkg::CSL_OFF;
            end else if (sys_error_i) begin
               state_d = csl_pkg::CSL_EMPTY_SYSERR;
            end else if (cmd[csl_pkg::CMD_DOWNLOAD] &&
                         !(state_q == csl_pkg::CSL_HALT && locked_q)) begin
               state_d = csl_pkg::CSL_STOPPED;
            end else if (state_q == csl_pkg::CSL_EMPTY ||
                         state_q == csl_pkg::CSL_EMPTY_SYSERR) begin
               state_d = state_q;
            end else if (fatal_error_i) begin
               state_d = csl_pkg::CSL_HALT;
            end else if (app_error_i && (state_q == csl_pkg::CSL_RUN ||
                                         state_q == csl_pkg::CSL_RUN_BP)) begin
               state_d = csl_pkg::CSL_HALT;
            end else if (any_reset &&
                         !(state_q == csl_pkg::CSL_HALT && locked_q)) begin
               // origin reset drops the application
               state_d = cmd[csl_pkg::CMD_RST_ORIG] ?
                  csl_pkg::CSL_EMPTY : csl_pkg::CSL_STOPPED;
            end else if (state_q == csl_pkg::CSL_HALT) begin
               state_d = csl_pkg::CSL_HALT;
            end else if (state_q == csl_pkg::CSL_STOPPED) begin
               if (cmd[csl_pkg::CMD_RUN]) begin
                  state_d = csl_pkg::CSL_RUN;
               end
            end else if (cmd[csl_pkg::CMD_STOP]) begin
               state_d = csl_pkg::CSL_STOPPED;
            end else if (cmd[csl_pkg::CMD_BP_SET]) begin
               state_d = csl_pkg::CSL_RUN_BP;
            end else if (cmd[csl_pkg::CMD_BP_CLR]) begin
               state_d = csl_pkg::CSL_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= csl_pkg::CSL_BOOT;
      end else begin
         state_q <= state_d;
      end
   end

   //==========================================================================
   // indicators
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         run_led_o <= 1'b0;
         err_led_o <= 1'b0;
         io_led_o <= 1'b0;
      end else begin
         run_led_o <= 1'b0;
         err_led_o <= 1'b0;
         io_led_o <= 1'b0;
         case (state_q)
            csl_pkg::CSL_BOOT: begin
               run_led_o <= (boot_phase_q == 2'h0);
               err_led_o <= (boot_phase_q != 2'h0);
               io_led_o <= (boot_phase_q == 2'h1);
            end
            csl_pkg::CSL_FW_MISSING:
               err_led_o <= pattern[csl_pkg::PAT_REG];
            csl_pkg::CSL_EMPTY:
               err_led_o <= pattern[csl_pkg::PAT_SGL];
            csl_pkg::CSL_EMPTY_SYSERR:
               err_led_o <= pattern[csl_pkg::PAT_FST];
            csl_pkg::CSL_RUN: begin
               run_led_o <= 1'b1;
               err_led_o <= unsaved_q & pattern[csl_pkg::PAT_SGL];
               io_led_o <= ext_err;
            end
            csl_pkg::CSL_RUN_BP: begin
               run_led_o <= pattern[csl_pkg::PAT_SGL];
               err_led_o <= unsaved_q & pattern[csl_pkg::PAT_SGL];
               io_led_o <= ext_err;
            end
            csl_pkg::CSL_STOPPED: begin
               run_led_o <= pattern[csl_pkg::PAT_REG];
               err_led_o <= unsaved_q & pattern[csl_pkg::PAT_SGL];
               io_led_o <= ext_err;
            end
            csl_pkg::CSL_HALT: begin
               run_led_o <= pattern[csl_pkg::PAT_REG];
               err_led_o <= 1'b1;
               io_led_o <= ext_err;
            end
            default: begin
               run_led_o <= 1'b0;
            end
         endcase
      end
   end

   // tasks stop at a breakpoint, in halt and in every other state
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         task_enable_o <= 1'b0;
         shutdown_o <= 1'b0;
      end else begin
         task_enable_o <= (state_d == csl_pkg::CSL_RUN);
         shutdown_o <= (state_d == csl_pkg::CSL_OFF);
      end
   end

   //==========================================================================
   // interrupts; a new event wins over a clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ext_err_prev_q <= 1'b0;
         pwr_prev_q <= 1'b0;
      end else begin
         ext_err_prev_q <= ext_err;
         pwr_prev_q <= power_fail_i;
      end
   end
   assign events[csl_pkg::EV_STATE] = (state_d != state_q);
   assign events[csl_pkg::EV_IO_ERR] = ext_err & ~ext_err_prev_q;
   assign events[csl_pkg::EV_HALT] = (state_d == csl_pkg::CSL_HALT) &&
      (state_q != csl_pkg::CSL_HALT);
   assign events[csl_pkg::EV_PWR] = power_fail_i & ~pwr_prev_q;
   assign events[csl_pkg::EV_SYSERR] =
      (state_d == csl_pkg::CSL_EMPTY_SYSERR) &&
      (state_q != csl_pkg::CSL_EMPTY_SYSERR);

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_stat_q <= 5'h00;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_en_q <= csl_pkg::IRQ_EN_RESET;
      end else if (wr_i && addr_i == csl_pkg::ADDR_IRQ_EN) begin
         irq_en_q <= wdata_i[4:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((irq_stat_q & ~irq_clr) | events) & irq_en_q);
      end
   end

   //==========================================================================
   // state word and read port
   always_comb begin
      case (state_q)
         csl_pkg::CSL_BOOT: code = csl_pkg::CODE_BOOT;
         csl_pkg::CSL_FW_MISSING: code = csl_pkg::CODE_FW_MISSING;
         csl_pkg::CSL_EMPTY: code = csl_pkg::CODE_EMPTY;
         csl_pkg::CSL_EMPTY_SYSERR: code = csl_pkg::CODE_EMPTY_SYSERR;
         csl_pkg::CSL_RUN: code = csl_pkg::CODE_RUN;
         csl_pkg::CSL_RUN_BP: code = csl_pkg::CODE_RUN_BP;
         csl_pkg::CSL_STOPPED: code = csl_pkg::CODE_STOPPED;
         csl_pkg::CSL_HALT: code = csl_pkg::CODE_HALT;
         default: code = csl_pkg::CODE_OFF;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         rdata_o <= 32'h0000_0000;
         case (addr_i)
            csl_pkg::ADDR_STATE: begin
               rdata_o[csl_pkg::SW_CODE_LSB +: 4] <= code;
               rdata_o[csl_pkg::SW_EXT_ERR] <= ext_err;
               rdata_o[csl_pkg::SW_UNSAVED] <= unsaved_q;
               rdata_o[csl_pkg::SW_LOCKED] <= locked_q;
               rdata_o[csl_pkg::SW_TASKS] <= task_enable_o;
               rdata_o[csl_pkg::SW_PHASE_LSB +: 2] <= boot_phase_q;
            end
            csl_pkg::ADDR_FAULT1: rdata_o <= fault1_q;
            csl_pkg::ADDR_FAULT2: rdata_o <= fault2_q;
            csl_pkg::ADDR_IRQ_STAT: rdata_o[4:0] <= irq_stat_q;
            csl_pkg::ADDR_IRQ_EN: rdata_o[4:0] <= irq_en_q;
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

endmodule : csl_top
`default_nettype wire

// File: csl_pkg.sv
// constants, types and register map of the controller state indicator block
//=============================================================================
// Overview of operation
// - boot self-tests, checksum checks; indicators step run, err+io, err.
// - no valid firmware: firmware-missing, nothing runs, error regular flash.
// - no application held: empty state, error indicator single flash.
// - system error: empty variant, error fast flash; download or power exits.
// - running a valid application: run indicator steady on, others off.
// - breakpoint suspends tasks until cleared; run indicator single flash.
// - I/O error while running: run on, I/O on, fault words recorded.
// - valid application not executing: stopped, run indicator regular flash.
// - I/O error while stopped: run regular flash, I/O on, error off.
// - application error stops execution: halt, run regular flash, error on.
// - unsaved boot application: error single flash; power cycle restores.
// - current operating state readable through the controller state word.
// - halt exits by reset, download, power or system error; after fatal only power or system error.
// - supply loss while running keeps running state at least 4 ms.
package csl_pkg;

   //==========================================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYCLES =
      (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TICK_W = 15;
   localparam int unsigned HOLDUP_NS = 4000000;
   localparam int unsigned HOLDUP_CYCLES =
      (HOLDUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_W = 17;
   // all flash and boot periods in 1 ms ticks
   localparam int unsigned MS_W = 11;
   localparam logic [10:0] BOOT_PHASE_MS = 11'h064;
   localparam logic [10:0] REG_ON_MS = 11'h0C8;
   localparam logic [10:0] REG_OFF_MS = 11'h0C8;
   localparam logic [10:0] SGL_ON_MS = 11'h0C8;
   localparam logic [10:0] SGL_OFF_MS = 11'h3E8;
   localparam logic [10:0] FST_ON_MS = 11'h032;
   localparam logic [10:0] FST_OFF_MS = 11'h032;
   localparam int unsigned PAT_REG = 0;
   localparam int unsigned PAT_SGL = 1;
   localparam int unsigned PAT_FST = 2;

   //==========================================================================
   // register map, byte addresses
   localparam logic [7:0] ADDR_STATE = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_FAULT1 = 8'h08;
   localparam logic [7:0] ADDR_FAULT2 = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

   // command word bits, write-only pulses
   localparam int unsigned CMD_RUN = 0;
   localparam int unsigned CMD_STOP = 1;
   localparam int unsigned CMD_RST_WARM = 2;
   localparam int unsigned CMD_RST_COLD = 3;
   localparam int unsigned CMD_RST_ORIG = 4;
   localparam int unsigned CMD_DOWNLOAD = 5;
   localparam int unsigned CMD_BP_SET = 6;
   localparam int unsigned CMD_BP_CLR = 7;
   localparam int unsigned CMD_ONLINE = 8;
   localparam int unsigned CMD_SAVE_BOOT = 9;
   localparam int unsigned CMD_W = 10;

   // state word fields
   localparam int unsigned SW_CODE_LSB = 0;
   localparam int unsigned SW_EXT_ERR = 8;
   localparam int unsigned SW_UNSAVED = 9;
   localparam int unsigned SW_LOCKED = 10;
   localparam int unsigned SW_TASKS = 11;
   localparam int unsigned SW_PHASE_LSB = 12;

   // interrupt events
   localparam int unsigned EV_STATE = 0;
   localparam int unsigned EV_IO_ERR = 1;
   localparam int unsigned EV_HALT = 2;
   localparam int unsigned EV_PWR = 3;
   localparam int unsigned EV_SYSERR = 4;
   localparam int unsigned EV_W = 5;
   localparam logic [4:0] IRQ_EN_RESET = 5'h00;

   //==========================================================================
   // controller states
   typedef enum logic [8:0] {
      CSL_BOOT = 9'h001,
      CSL_FW_MISSING = 9'h002,
      CSL_EMPTY = 9'h004,
      CSL_EMPTY_SYSERR = 9'h008,
      CSL_RUN = 9'h010,
      CSL_RUN_BP = 9'h020,
      CSL_STOPPED = 9'h040,
      CSL_HALT = 9'h080,
      CSL_OFF = 9'h100
   } csl_state_e;

   // state codes as read back in the state word
   localparam logic [3:0] CODE_BOOT = 4'h0;
   localparam logic [3:0] CODE_FW_MISSING = 4'h1;
   localparam logic [3:0] CODE_EMPTY = 4'h2;
   localparam logic [3:0] CODE_EMPTY_SYSERR = 4'h3;
   localparam logic [3:0] CODE_RUN = 4'h4;
   localparam logic [3:0] CODE_RUN_BP = 4'h5;
   localparam logic [3:0] CODE_STOPPED = 4'h6;
   localparam logic [3:0] CODE_HALT = 4'h7;
   localparam logic [3:0] CODE_OFF = 4'h8;

endpackage : csl_pkg

// File: csl_flash.sv
// flash waveform generator for the status indicators
`timescale 1ns/1ns
`default_nettype none
module csl_flash (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // 1 ms tick
   input wire logic tick_i,
   // regular, single and fast waveforms
   output logic [2:0] pattern_o
);

   //==========================================================================
   // one on/off counter per pattern
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pat
         localparam logic [10:0] ON_MS = (g == csl_pkg::PAT_REG) ?
            csl_pkg::REG_ON_MS : (g == csl_pkg::PAT_SGL) ?
            csl_pkg::SGL_ON_MS : csl_pkg::FST_ON_MS;
         localparam logic [10:0] OFF_MS = (g == csl_pkg::PAT_REG) ?
            csl_pkg::REG_OFF_MS : (g == csl_pkg::PAT_SGL) ?
            csl_pkg::SGL_OFF_MS : csl_pkg::FST_OFF_MS;
         logic [10:0] cnt_q;
         logic on_q;
         always_ff @(posedge mclk_i) begin
            if (reset_i) begin
               cnt_q <= 11'h000;
               on_q <= 1'b0;
            end else if (tick_i) begin
               // phase ends: flip and restart the count
               if (cnt_q == ((on_q ? ON_MS : OFF_MS) - 11'h001)) begin
                  cnt_q <= 11'h000;
                  on_q <= ~on_q;
               end else begin
                  cnt_q <= cnt_q + 11'h001;
               end
            end
         end
         assign pattern_o[g] = on_q;
      end
   endgenerate

endmodule : csl_flash
`default_nettype wire

// File: csl_props.sv
// checker of the state tracker outputs
`timescale 1ns/1ns
`default_nettype none
module csl_props (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // inputs watched
   input wire logic app_error_i,
   input wire logic power_fail_i,
   input wire logic [31:0] fault_first_i,
   input wire logic [31:0] fault_second_i,
   input wire logic rd_i,
   // outputs watched
   input wire logic [31:0] rdata_o,
   input wire logic run_led_o,
   input wire logic err_led_o,
   input wire logic io_led_o,
   input wire logic task_enable_o,
   input wire logic shutdown_o
);
   //==========================================================
   // assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read slot");
   AST_RUN_STEADY: assert property (
      task_enable_o && $past(task_enable_o) |-> run_led_o)
      else $error("run indicator not steady while running");
   AST_SHUT_EXCL: assert property (shutdown_o |-> !task_enable_o)
      else $error("shutdown while tasks run");
   AST_HOLDUP: assert property (
      $rose(power_fail_i) && task_enable_o |-> !shutdown_o [*8])
      else $error("shutdown before hold-up interval");
   AST_IO_ON: assert property (
      (task_enable_o && |fault_first_i) [*4] |-> io_led_o)
      else $error("io indicator dark with fault");
   AST_IO_OFF: assert property (
      (task_enable_o && fault_first_i == 32'h0 &&
       fault_second_i == 32'h0) [*4] |-> !io_led_o)
      else $error("io indicator lit without fault");
   AST_HALT_STOP: assert property (
      app_error_i && task_enable_o |-> ##[1:3] !task_enable_o)
      else $error("tasks kept running after application error");
   AST_HALT_ERR: assert property (
      app_error_i && task_enable_o |-> ##[2:4] err_led_o)
      else $error("error indicator dark in halt");
endmodule : csl_props
bind csl_top csl_props i_props (.mclk_i, .reset_i, .app_error_i, .power_fail_i,
   .fault_first_i, .fault_second_i, .rd_i, .rdata_o, .run_led_o, .err_led_o,
   .io_led_o, .task_enable_o, .shutdown_o);
`default_nettype wire

// File: csl_led_model.sv
// model of the run and error front-panel indicators
`timescale 1ns/1ns
`default_nettype none
module csl_led_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // indicator lines
   input wire logic run_i,
   input wire logic err_i,
   // lightings counted per indicator
   output int run_n_o,
   output int err_n_o
);
   //==========================================================
   // counting, a lamp only shows edges
   logic [1:0] last_q;
   always_ff @(posedge mclk_i) begin
      last_q <= {run_i, err_i};
      if (reset_i) begin
         run_n_o <= 0;
         err_n_o <= 0;
      end else begin
         run_n_o <= run_n_o + int'(run_i && !last_q[1]);
         err_n_o <= err_n_o + int'(err_i && !last_q[0]);
      end
   end
endmodule : csl_led_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the state tracker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   //==========================================================
   // signals, tick shortened to 2 cycles
   logic mclk_i = 1'b0, reset_i = 1'b1, st = 1'b1, fw = 1'b1, ap = 1'b1;
   logic se = 1'b0, ae = 1'b0, fe = 1'b0, pf = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [31:0] f1 = 32'h0, f2 = 32'h0, wd = 32'h0, rdata_o, d;
   logic [7:0] addr_i = 8'h00;
   logic run_o, err_o, io_o, ten_o, sd_o, irq_o;
   int bad_count = 0, samples_checked = 0, cyc = 0, seed = 32417;
   int rn, en, r0, e0;
   csl_top #(.TICK_CYCLES(2), .HOLDUP_CYCLES(20)) i_dut (.mclk_i(mclk_i),
      .reset_i(reset_i), .selftest_done_i(st), .fw_valid_i(fw),
      .app_valid_i(ap), .sys_error_i(se), .app_error_i(ae),
      .fatal_error_i(fe), .power_fail_i(pf), .fault_first_i(f1),
      .fault_second_i(f2), .addr_i(addr_i), .wdata_i(wd), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .run_led_o(run_o), .err_led_o(err_o),
      .io_led_o(io_o), .task_enable_o(ten_o), .shutdown_o(sd_o),
      .irq_o(irq_o));
   csl_led_model i_leds (.mclk_i(mclk_i), .reset_i(reset_i), .run_i(run_o),
      .err_i(err_o), .run_n_o(rn), .err_n_o(en));
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wd <= v;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic code(input logic [3:0] c);
      rd(csl_pkg::ADDR_STATE);
      chk({28'h0, d[3:0]}, {28'h0, c}, "state code");
   endtask : code
   task automatic cmd(input int b, input logic [3:0] c);
      wr(csl_pkg::ADDR_CMD, 32'h1 << b);
      code(c);
   endtask : cmd
   task automatic win(input int n);
      r0 = rn;
      e0 = en;
      wt(n);
      r0 = rn - r0;
      e0 = en - e0;
   endtask : win
   task automatic boot(input logic f, a, input logic [3:0] c);
      int i;
      reset_i <= 1'b1;
      fw <= f;
      ap <= a;
      wt(8);
      reset_i <= 1'b0;
      wt(3);
      chk({run_o, err_o, io_o}, 32'h4, "boot leds");
      wt(210);
      chk({run_o, err_o, io_o}, 32'h3, "boot leds");
      wt(202);
      chk({run_o, err_o, io_o}, 32'h2, "boot leds");
      for (i = 0; i < 200 && d[3:0] !== c; i++) rd(csl_pkg::ADDR_STATE);
      code(c);
   endtask : boot
   //==========================================================
   // main sequence
   initial begin
      boot(1'b0, 1'b1, csl_pkg::CODE_FW_MISSING);
      win(900);
      chk(32'(e0 != 0 && r0 == 0), 1, "error flash");
      boot(1'b1, 1'b0, csl_pkg::CODE_EMPTY);
      win(2500);
      chk(32'(e0 != 0 && r0 == 0), 1, "error single");
      boot(1'b1, 1'b1, csl_pkg::CODE_STOPPED);
      win(900);
      chk(32'(r0 != 0 && e0 == 0 && !io_o), 1, "run flash");
      wr(csl_pkg::ADDR_IRQ_CLR, 32'h1F);
      wr(csl_pkg::ADDR_IRQ_EN, 32'h0);
      cmd(csl_pkg::CMD_RUN, csl_pkg::CODE_RUN);
      rd(csl_pkg::ADDR_IRQ_STAT);
      chk(d & 32'h1, 32'h1, "irq status");
      chk(irq_o, 1'b0, "irq masked");
      wr(csl_pkg::ADDR_IRQ_EN, 32'h1F);
      wt(2);
      chk(irq_o, 1'b1, "irq raised");
      wr(csl_pkg::ADDR_IRQ_CLR, 32'h1F);
      wt(2);
      chk(irq_o, 1'b0, "irq cleared");
      win(900);
      chk(32'(r0 == 0 && e0 == 0 && run_o), 1, "run steady");
      cmd(csl_pkg::CMD_ONLINE, csl_pkg::CODE_RUN);
      chk(d[9], 1'b1, "unsaved");
      win(2500);
      chk(32'(e0 != 0), 1, "unsaved flash");
      cmd(csl_pkg::CMD_SAVE_BOOT, csl_pkg::CODE_RUN);
      chk(d[9], 1'b0, "unsaved");
      f1 <= 32'($random(seed)) | 32'h1;
      f2 <= 32'($random(seed));
      wt(4);
      rd(csl_pkg::ADDR_FAULT1);
      chk(d, f1, "fault first");
      rd(csl_pkg::ADDR_FAULT2);
      chk(d, f2, "fault second");
      chk(io_o, 1'b1, "io lit");
      f1 <= 32'h0;
      f2 <= 32'h0;
      cmd(csl_pkg::CMD_BP_SET, csl_pkg::CODE_RUN_BP);
      win(2500);
      chk(32'(r0 != 0 && !ten_o && !io_o), 1, "breakpoint");
      cmd(csl_pkg::CMD_BP_CLR, csl_pkg::CODE_RUN);
      ae <= 1'b1;
      wt(1);
      ae <= 1'b0;
      code(csl_pkg::CODE_HALT);
      chk(err_o, 1'b1, "halt error");
      cmd(csl_pkg::CMD_RUN, csl_pkg::CODE_HALT);
      cmd(csl_pkg::CMD_RST_WARM, csl_pkg::CODE_STOPPED);
      cmd(csl_pkg::CMD_RUN, csl_pkg::CODE_RUN);
      fe <= 1'b1;
      wt(1);
      fe <= 1'b0;
      cmd(csl_pkg::CMD_RST_WARM, csl_pkg::CODE_HALT);
      cmd(csl_pkg::CMD_DOWNLOAD, csl_pkg::CODE_HALT);
      se <= 1'b1;
      wt(1);
      se <= 1'b0;
      code(csl_pkg::CODE_EMPTY_SYSERR);
      win(300);
      chk(32'(e0 != 0 && r0 == 0), 1, "error fast");
      cmd(csl_pkg::CMD_DOWNLOAD, csl_pkg::CODE_STOPPED);
      cmd(csl_pkg::CMD_RUN, csl_pkg::CODE_RUN);
      pf <= 1'b1;
      wt(5);
      chk(sd_o, 1'b0, "hold-up");
      wt(30);
      chk(sd_o, 1'b1, "shutdown");
      code(csl_pkg::CODE_OFF);
      rd(8'h40);
      chk(d, 32'h0, "unmapped");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
